// [hdl/err_pkg.sv]
// shared types and constants of the serial bus error handler
package err_pkg;

    // width of one bus data byte
    localparam int DATA_W = 8;

    // reset contents of the bus data register
    localparam logic [DATA_W-1:0] DATA_REG_RESET = 8'h00;

    // reset level of every flag and pulse
    localparam logic FLAG_RESET = 1'b0;

    // link states of this unit
    typedef enum logic [1:0] {
        ST_WAIT_START,
        ST_RECEIVE,
        ST_TRANSMIT
    } link_state_t;

    // per-cycle view of the frame engine
    typedef struct packed {
        logic start_bit;           // start bit seen, frame begins
        logic tx_mode;             // this unit transmits the frame
        logic broadcast;           // frame is a broadcast frame
        logic data_field;          // current byte lies in the data field
        logic rx_done;             // a byte and its parity have arrived
        logic rx_parity_ok;        // received parity agrees with the bits
        logic tx_due;              // the next byte must be sent now
        logic [DATA_W-1:0] rx_byte; // received byte
    } link_evt_t;

    // accesses to the bus data register by cpu or dma
    typedef struct packed {
        logic reg_read;            // read strobe of the data register
        logic reg_write;           // write strobe of the data register
        logic [DATA_W-1:0] wdata;  // byte written
    } cpu_acc_t;

    // actions requested from the frame engine
    typedef struct packed {
        logic comm_error_interrupt; // communication error interrupt
        logic nack;                 // answer the byte with a negative ack
        logic abort;                // stop and wait for a start bit
        logic tx_load;              // byte taken for transmission
    } resp_t;

    // sticky error flags
    typedef struct packed {
        logic overrun;
        logic underrun;
        logic parity;
    } err_flags_t;

endpackage

// [hdl/sticky_flag.sv]
// sticky status flag where a set beats a simultaneous clear
module sticky_flag
    import err_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic set,
    input wire logic clr,
    output logic flag_q
);

    logic flag_d; // next flag level

    // set has priority so an event in the clearing cycle is kept
    always_comb begin
        flag_d = flag_q;
        if (set) begin
            flag_d = 1'b1;
        end else if (clr) begin
            flag_d = 1'b0;
        end
    end

    // register, frozen while the clock enable is low
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flag_q <= FLAG_RESET;
        end else if (clk_en) begin
            flag_q <= flag_d;
        end
    end

endmodule

// [hdl/bus_err_handler.sv]
// error detection and recovery of the serial bus data path
// Operation
// - overrun when unread byte meets next data byte
// - broadcast data overrun: stop, interrupt, await start
// - refuse data until overrun cleared by read
// - individual data overrun: nack, no interrupt
// - underrun: stop, interrupt, await start bit
// - parity outside data field: stop, interrupt
// - individual data parity: nack, keep receiving
module bus_err_handler
    import err_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire link_evt_t link,
    input wire cpu_acc_t cpu,
    output resp_t resp_q,
    output err_flags_t flags_q,
    output logic [DATA_W-1:0] bus_data_register,
    output logic reg_full,
    output link_state_t state
);

    link_state_t state_q; // link state register
    link_state_t state_d; // its next value
    logic [DATA_W-1:0] data_q; // bus data register contents
    logic [DATA_W-1:0] data_d;
    logic full_q; // rx: unread byte held, tx: byte ready to send
    logic full_d;
    resp_t resp_d; // next action pulses
    logic set_ovr; // overrun seen this cycle
    logic set_udr; // underrun seen this cycle
    logic set_par; // parity error seen this cycle
    logic rx_ev; // byte arrival while receiving
    logic tx_ev; // byte due while transmitting

    assign rx_ev = (state_q == ST_RECEIVE) && link.rx_done;
    assign tx_ev = (state_q == ST_TRANSMIT) && link.tx_due;

    // next state, data register and actions for each byte event
    always_comb begin
        state_d = state_q;
        data_d = data_q;
        full_d = full_q;
        resp_d = '0;
        set_ovr = 1'b0;
        set_udr = 1'b0;
        set_par = 1'b0;
        // cpu side: a read empties the register except in transmit, a write fills it except in receive
        if (cpu.reg_read && state_q != ST_TRANSMIT) begin
            full_d = 1'b0;
        end
        if (cpu.reg_write && state_q != ST_RECEIVE) begin
            data_d = cpu.wdata;
            full_d = 1'b1;
        end
        case (state_q)
            ST_WAIT_START: begin
                // a new frame starts in the direction the engine says
                if (link.start_bit) begin
                    state_d = link.tx_mode ? ST_TRANSMIT : ST_RECEIVE;
                end
            end
            ST_RECEIVE: begin
                if (rx_ev && !link.rx_parity_ok) begin
                    set_par = 1'b1;
                    if (!link.data_field) begin
                        // header bytes cannot be repeated: give up
                        resp_d.comm_error_interrupt = 1'b1;
                        resp_d.abort = 1'b1;
                        state_d = ST_WAIT_START;
                    end else if (link.broadcast) begin
                        // nobody repeats a broadcast byte
                        resp_d.comm_error_interrupt = 1'b1;
                        resp_d.abort = 1'b1;
                        state_d = ST_WAIT_START;
                    end else begin
                        // sender retransmits, byte is dropped here
                        resp_d.nack = 1'b1;
                    end
                end else if (rx_ev && link.data_field
                             && (full_q || flags_q.overrun)) begin
                    // unread byte or uncleared overrun: refuse byte
                    set_ovr = 1'b1;
                    if (link.broadcast) begin
                        resp_d.comm_error_interrupt = 1'b1;
                        resp_d.abort = 1'b1;
                        state_d = ST_WAIT_START;
                    end else begin
                        resp_d.nack = 1'b1;
                    end
                end else if (rx_ev && link.data_field) begin
                    // good data byte goes to the register
                    data_d = link.rx_byte;
                    full_d = 1'b1;
                end
            end
            ST_TRANSMIT: begin
                if (tx_ev && link.data_field && !full_q) begin
                    // register not refilled in time
                    set_udr = 1'b1;
                    resp_d.comm_error_interrupt = 1'b1;
                    resp_d.abort = 1'b1;
                    state_d = ST_WAIT_START;
                end else if (tx_ev && link.data_field) begin
                    // the engine takes the byte; a write in this
                    // same cycle refills it
                    resp_d.tx_load = 1'b1;
                    full_d = cpu.reg_write;
                end
            end
            default: begin
                state_d = ST_WAIT_START;
            end
        endcase
    end

    // register all state; clk_en low freezes everything
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            state_q <= ST_WAIT_START;
            data_q <= DATA_REG_RESET;
            full_q <= FLAG_RESET;
            resp_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            data_q <= data_d;
            full_q <= full_d;
            resp_q <= resp_d;
        end
    end

    // overrun stays until software reads the data register
    sticky_flag u_ovr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .set(set_ovr),
        .clr(cpu.reg_read),
        .flag_q(flags_q.overrun)
    );

    // underrun stays until the next frame begins
    sticky_flag u_udr (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .set(set_udr),
        .clr(link.start_bit),
        .flag_q(flags_q.underrun)
    );

    // parity error stays until the next frame begins
    sticky_flag u_par (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .set(set_par),
        .clr(link.start_bit),
        .flag_q(flags_q.parity)
    );

    assign bus_data_register = data_q;
    assign reg_full = full_q;
    assign state = state_q;

    // a full register meeting a new data byte is an overrun
    overrun_seen_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && rx_ev && link.rx_parity_ok && link.data_field
        && full_q |=> flags_q.overrun)
        else $error("overrun not flagged");

    // broadcast overrun ends reception with an interrupt
    bc_ovr_stop_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && set_ovr && link.broadcast
        |=> resp_q.comm_error_interrupt && resp_q.abort
        && state_q == ST_WAIT_START)
        else $error("broadcast overrun did not stop");

    // refused bytes never reach the register
    ovr_refuse_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && rx_ev && flags_q.overrun && !cpu.reg_read
        |=> $stable(data_q))
        else $error("byte stored during overrun");

    // individual overrun answers nack and keeps quiet
    ind_ovr_nack_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && set_ovr && !link.broadcast
        |=> resp_q.nack && !resp_q.comm_error_interrupt
        && state_q == ST_RECEIVE)
        else $error("individual overrun handled wrongly");

    // underrun stops transmission with an interrupt
    udr_stop_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && tx_ev && link.data_field && !full_q
        |=> flags_q.underrun && resp_q.comm_error_interrupt
        && state_q == ST_WAIT_START)
        else $error("underrun not handled");

    // header parity error aborts
    hdr_par_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && rx_ev && !link.rx_parity_ok && !link.data_field
        |=> resp_q.abort ##0 resp_q.comm_error_interrupt)
        else $error("header parity not aborted");

    // broadcast data parity error aborts
    bc_par_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && rx_ev && !link.rx_parity_ok && link.data_field
        && link.broadcast |=> resp_q.abort && flags_q.parity)
        else $error("broadcast parity not aborted");

    // individual data parity error keeps receiving
    ind_par_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && rx_ev && !link.rx_parity_ok && link.data_field
        && !link.broadcast |=> resp_q.nack && !resp_q.abort
        && state_q == ST_RECEIVE)
        else $error("individual parity handled wrongly");

    // header bytes leave clear overrun and underrun flags clear
    field_only_a: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        clk_en && (rx_ev || tx_ev) && !link.data_field
        && !flags_q.overrun && !flags_q.underrun
        |=> !flags_q.overrun && !flags_q.underrun)
        else $error("data-field error outside data field");

    // main scenarios
    cov_ind_ovr: cover property (@(posedge sys_clk)
        disable iff (!resetn) clk_en && set_ovr && !link.broadcast);
    cov_udr: cover property (@(posedge sys_clk)
        disable iff (!resetn) clk_en && set_udr);
    cov_par_nack: cover property (@(posedge sys_clk)
        disable iff (!resetn) clk_en && set_par && link.data_field
        && !link.broadcast);

endmodule

// [testbench/bus_peer.sv]
// behavioural model of the other units on the shared serial bus
module bus_peer
    import err_pkg::*;
(
    input wire logic sys_clk,
    output link_evt_t link
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle bus: no events, all levels low
    initial begin
        link = '0;
    end

    // one event cycle; pulses drop after one edge, stale byte is inverted
    task automatic fire(input link_evt_t e);
        @(posedge sys_clk);
        #1;
        link = e;
        @(posedge sys_clk);
        #1;
        link.start_bit = 1'b0;
        link.rx_done = 1'b0;
        link.tx_due = 1'b0;
        link.rx_byte = ~e.rx_byte; // held byte is no longer valid
    endtask

    // a start bit opens a frame; mode and kind stay as levels
    task automatic start(input logic tx, input logic bc);
        link_evt_t e;
        e = '0;
        e.start_bit = 1'b1;
        e.tx_mode = tx;
        e.broadcast = bc;
        fire(e);
    endtask

    // a byte arrives; a sender that sees nack simply calls this again
    task automatic byte_in(input logic [7:0] b, input logic ok,
                           input logic df);
        link_evt_t e;
        e = link;
        e.rx_done = 1'b1;
        e.rx_parity_ok = ok;
        e.data_field = df;
        e.rx_byte = b;
        fire(e);
    endtask

    // the bus asks this unit for its next byte
    task automatic due(input logic df);
        link_evt_t e;
        e = link;
        e.tx_due = 1'b1;
        e.data_field = df;
        fire(e);
    endtask
endmodule

// [testbench/test_bus_err_handler.sv]
// self-checking bench of the serial bus error handler
module test_bus_err_handler;
    timeunit 1ns;
    timeprecision 100ps;
    import err_pkg::*;

    logic sys_clk;
    logic resetn;
    link_evt_t link;
    cpu_acc_t cpu;
    resp_t resp_q;
    err_flags_t flags_q;
    logic [DATA_W-1:0] bus_data_register;
    logic reg_full;
    logic clk_en;
    link_state_t state;
    int fail_count = 0;
    int cmp_count = 0;

    bus_err_handler dut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .link(link), .cpu(cpu), .resp_q(resp_q),
        .flags_q(flags_q), .bus_data_register(bus_data_register),
        .reg_full(reg_full), .state(state));
    bus_peer peer (.sys_clk(sys_clk), .link(link));

    // 250 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // one comparison; unknowns never match
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask

    // response pulses and state seen after the taking edge
    task automatic see(input logic [3:0] ina, input link_state_t st);
        chk({4'h0, resp_q.comm_error_interrupt, resp_q.nack,
             resp_q.abort, resp_q.tx_load}, {4'h0, ina});
        chk({6'h00, state}, {6'h00, st});
    endtask

    // one cpu or dma access to the data register
    task automatic acc(input logic rd, input logic wr,
                       input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        cpu = '{reg_read: rd, reg_write: wr, wdata: d};
        @(posedge sys_clk);
        #1;
        cpu = '{reg_read: 1'b0, reg_write: 1'b0, wdata: ~d};
    endtask

    // individual reception: overrun nacks, refuses until read
    task automatic t_overrun_ind();
        peer.start(1'b0, 1'b0);
        peer.byte_in(8'h5A, 1'b1, 1'b1);
        chk(bus_data_register, 8'h5A);
        peer.byte_in(8'hC3, 1'b1, 1'b1);
        see(4'h4, ST_RECEIVE);
        chk({7'h00, flags_q.overrun}, 8'h01);
        acc(1'b0, 1'b0, 8'h00);
        peer.byte_in(8'hC3, 1'b1, 1'b1);
        chk(bus_data_register, 8'h5A);
        acc(1'b1, 1'b0, 8'h00);
        chk({7'h00, flags_q.overrun}, 8'h00);
        peer.byte_in(8'hC3, 1'b1, 1'b1);
        chk(bus_data_register, 8'hC3);
        peer.byte_in(8'h3C, 1'b1, 1'b0);
        chk({7'h00, flags_q.overrun}, 8'h00);
        $display("test overrun individual done");
    endtask

    // parity errors in header and data field, and broadcast overrun
    task automatic t_parity_bcast();
        peer.byte_in(8'h11, 1'b0, 1'b0);
        see(4'hA, ST_WAIT_START);
        acc(1'b1, 1'b0, 8'h00);
        peer.start(1'b0, 1'b0);
        peer.byte_in(8'h22, 1'b0, 1'b1);
        see(4'h4, ST_RECEIVE);
        chk({7'h00, flags_q.parity}, 8'h01);
        peer.byte_in(8'h22, 1'b1, 1'b1);
        chk(bus_data_register, 8'h22);
        peer.byte_in(8'h44, 1'b1, 1'b0);
        peer.byte_in(8'h44, 1'b0, 1'b1);
        see(4'h4, ST_RECEIVE);
        acc(1'b1, 1'b0, 8'h00);
        peer.byte_in(8'h55, 1'b0, 1'b0);
        peer.start(1'b0, 1'b1);
        peer.byte_in(8'h66, 1'b0, 1'b1);
        see(4'hA, ST_WAIT_START);
        peer.start(1'b0, 1'b1);
        peer.byte_in(8'h77, 1'b1, 1'b1);
        peer.byte_in(8'h88, 1'b1, 1'b1);
        see(4'hA, ST_WAIT_START);
        chk(bus_data_register, 8'h77);
        acc(1'b1, 1'b0, 8'h00);
        $display("test parity and broadcast done");
    endtask

    // transmission: byte taken, header skipped, then underrun
    task automatic t_underrun();
        peer.start(1'b1, 1'b0);
        acc(1'b0, 1'b1, 8'hA5);
        chk({7'h00, reg_full}, 8'h01);
        peer.due(1'b0);
        see(4'h0, ST_TRANSMIT);
        peer.due(1'b1);
        see(4'h1, ST_TRANSMIT);
        // empty register in the header: still no underrun
        peer.due(1'b0);
        see(4'h0, ST_TRANSMIT);
        chk({7'h00, flags_q.underrun}, 8'h00);
        peer.due(1'b1);
        see(4'hA, ST_WAIT_START);
        chk({7'h00, flags_q.underrun}, 8'h01);
        // a frozen unit ignores the start bit and keeps its flag
        clk_en = 1'b0;
        peer.start(1'b0, 1'b0);
        chk({7'h00, flags_q.underrun}, 8'h01);
        chk({6'h00, state}, {6'h00, ST_WAIT_START});
        clk_en = 1'b1;
        $display("test underrun done");
    endtask

    // verdict and end of run
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // cuts a hang short
    initial begin
        repeat (5000) @(posedge sys_clk);
        fail_count++;
        tally_and_finish();
    end

    // reset for ten cycles, then the scenarios
    initial begin
        resetn = 1'b0;
        clk_en = 1'b1;
        cpu = '0;
        repeat (10) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        see(4'h0, ST_WAIT_START);
        t_overrun_ind();
        t_parity_bcast();
        t_underrun();
        tally_and_finish();
    end
endmodule
